//--- design/adcsr_pkg.sv
// Package of the serial readout block: frame size, states and timing counts.
// Assumes a 40 MHz system clock shared by both ends.
package adcsr_pkg;
    // ==========================================================
    // Frame and timing
    localparam int FRAME_BITS = 32;
    localparam int CLK_HZ = 40000000;
    localparam int CLK_NS = 25;
    // Status test delay with the internal oscillator, in ns
    localparam int STATUS_TEST_DELAY_NS = 23000;
    localparam int STATUS_TEST_CYCLES = (STATUS_TEST_DELAY_NS + CLK_NS - 1)
        / CLK_NS;
    // External oscillator case: 3.6 conversion clocks, in tenths
    localparam int STATUS_TEST_EXT_TENTHS = 36;
    // Internal serial clock is conversion clock divided by 8
    localparam int SCK_DIVIDE = 8;
    // Conversion clock period in system cycles (chosen)
    localparam int CONV_CLK_CYCLES = 4;
    // Conversion length in system cycles (shortened default)
    localparam int CONV_CYCLES = 2000;
    // Host external SCK half period in system cycles; long enough for
    // the device's SCK synchroniser plus the host's SDO synchroniser
    localparam int HOST_HALF_CYCLES = 8;
    // Result reset value
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

    // ==========================================================
    // Device states
    typedef enum logic [1:0]
    {
        ADCSR_CONVERT = 2'b00,
        ADCSR_SLEEP = 2'b01,
        ADCSR_TEST = 2'b10,
        ADCSR_OUTPUT = 2'b11
    } adcsr_state_t;
endpackage : adcsr_pkg

//--- design/adcsr_if.sv
// Link between the converter end and the host end.
// Assumes the testbench resolves the two-way SCK wire from the enables.
`timescale 1ns/100ps
interface adcsr_if;
    logic cs_n;
    logic sck_dev_o;
    logic sck_dev_oe;
    logic sck_pullup;
    logic sck_host_o;
    logic sck_host_oe;
    logic sck;
    logic sdo_o;
    logic sdo_oe;
    logic sdo;
    modport device
    (
        input cs_n, sck, output sck_dev_o, sck_dev_oe, sck_pullup,
        output sdo_o, sdo_oe
    );
    modport host
    (
        output cs_n, sck_host_o, sck_host_oe, input sck, sdo
    );
endinterface : adcsr_if

//--- design/adcsr_device.sv
// Converter end: mode select, busy flag, 32-bit shift out, conversion.
// Assumes cs_n and sck come from the host pins, asynchronous to clk.
`timescale 1ns/100ps
module adcsr_device
    import adcsr_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES,
    parameter int TEST_LEN = STATUS_TEST_CYCLES,
    parameter int CONV_DIV = CONV_CLK_CYCLES
)
(
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Rate select: high means external conversion clock times the status test delay
    input wire logic rate_select_pin,
    // Next result from the converter core
    input wire logic [31:0] result_in,
    // Status
    output logic busy,
    output logic int_mode,
    // Link
    adcsr_if.device link
);
    localparam int TEST_EXT = (STATUS_TEST_EXT_TENTHS * CONV_DIV + 9) / 10;
    localparam int HALF_SCK = SCK_DIVIDE * CONV_DIV / 2;

    typedef struct packed
    {
        logic [1:0] cs_s;
        logic [1:0] sck_s;
        logic [1:0] rate_s;
        logic [1:0] por;
        logic cs_d;
        logic sck_d;
        adcsr_state_t st;
        logic intm;
        logic pull;
        logic [31:0] shreg;
        logic [31:0] held;
        logic [5:0] edges;
        logic [15:0] cnt;
        logic sck_out;
        logic sdo;
        logic sdo_en;
        logic sck_en;
    } adcsr_dev_t;

    adcsr_dev_t r;
    adcsr_dev_t next_r;
    logic cs_fall;
    logic cs_rise;
    logic sck_fall;
    logic sck_rise;
    logic sck_now;
    logic cs_low;

    // ==========================================================
    // Next state
    always_comb
    begin
        next_r = r;
        next_r.cs_s = {r.cs_s[0], link.cs_n};
        next_r.sck_s = {r.sck_s[0], link.sck};
        next_r.cs_d = r.cs_s[1];
        next_r.sck_d = r.sck_s[1];
        next_r.rate_s = {r.rate_s[0], rate_select_pin};
        next_r.por = (r.por == 2'h3) ? r.por : r.por + 2'h1;
        cs_low = ~r.cs_s[1];
        sck_now = r.sck_s[1];
        cs_fall = r.cs_d & ~r.cs_s[1];
        cs_rise = ~r.cs_d & r.cs_s[1];
        sck_fall = r.sck_d & ~r.sck_s[1];
        sck_rise = ~r.sck_d & r.sck_s[1];

        if (r.por == 2'h2)
        begin
            // Reset over: SCK level, now synchronised, picks the mode
            next_r.intm = sck_now;
        end
        if (cs_fall)
        begin
            next_r.intm = sck_now;
        end
        if (cs_rise)
        begin
            next_r.pull = 1'b1;
        end
        else if (!sck_now)
        begin
            next_r.pull = 1'b0;
        end

        case (r.st)
            ADCSR_CONVERT:
            begin
                next_r.sdo = 1'b1;
                next_r.cnt = r.cnt + 16'h0001;
                if (r.cnt >= 16'(CONV_LEN - 1))
                begin
                    next_r.cnt = 16'h0000;
                    next_r.held = result_in;
                    next_r.shreg = result_in;
                    next_r.st = ADCSR_SLEEP;
                    next_r.sdo = 1'b0;
                end
            end
            ADCSR_SLEEP:
            begin
                next_r.sdo = 1'b0;
                next_r.edges = 6'h00;
                next_r.shreg = r.held;
                if (cs_low && next_r.intm)
                begin
                    next_r.st = ADCSR_TEST;
                    next_r.sck_out = 1'b0;
                    next_r.cnt = 16'h0000;
                end
                else if (cs_low && sck_rise)
                begin
                    next_r.st = ADCSR_OUTPUT;
                    next_r.edges = 6'h01;
                end
            end
            ADCSR_TEST:
            begin
                next_r.cnt = r.cnt + 16'h0001;
                if (!cs_low)
                begin
                    next_r.st = ADCSR_SLEEP;
                end
                else if (r.cnt >= 16'(r.rate_s[1] ? TEST_EXT : TEST_LEN))
                begin
                    next_r.st = ADCSR_OUTPUT;
                    next_r.sck_out = 1'b1;
                    next_r.edges = 6'h01;
                    next_r.cnt = 16'h0000;
                end
            end
            default:
            begin
                if (!cs_low)
                begin
                    next_r.st = ADCSR_CONVERT;
                    next_r.cnt = 16'h0000;
                    next_r.sck_out = 1'b1;
                end
                else if (r.intm)
                begin
                    next_r.cnt = r.cnt + 16'h0001;
                    if (r.cnt >= 16'(HALF_SCK - 1))
                    begin
                        next_r.cnt = 16'h0000;
                        if (r.sck_out && r.edges == 6'(FRAME_BITS))
                        begin
                            next_r.st = ADCSR_CONVERT;
                            next_r.sdo = 1'b1;
                        end
                        else if (r.sck_out)
                        begin
                            next_r.sck_out = 1'b0;
                            next_r.sdo = r.shreg[31];
                            next_r.shreg = {r.shreg[30:0], 1'b0};
                        end
                        else
                        begin
                            next_r.sck_out = 1'b1;
                            next_r.edges = r.edges + 6'h01;
                        end
                    end
                end
                else if (sck_fall)
                begin
                    next_r.sdo = r.shreg[31];
                    next_r.shreg = {r.shreg[30:0], 1'b0};
                    if (r.edges == 6'(FRAME_BITS))
                    begin
                        next_r.st = ADCSR_CONVERT;
                        next_r.sdo = 1'b1;
                        next_r.cnt = 16'h0000;
                    end
                end
                else if (sck_rise)
                begin
                    next_r.edges = r.edges + 6'h01;
                end
            end
        endcase
        next_r.sdo_en = ~r.cs_s[1];
        next_r.sck_en = next_r.intm & ~r.cs_s[1] &
            (next_r.st == ADCSR_TEST || next_r.st == ADCSR_OUTPUT);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r <= '{cs_s: 2'b11, sck_s: 2'b11, rate_s: 2'h0, por: 2'h0,
                   cs_d: 1'b1, sck_d: 1'b1,
                   st: ADCSR_CONVERT, intm: 1'b1, pull: 1'b1,
                   shreg: RESULT_RESET, held: RESULT_RESET, edges: 6'h00,
                   cnt: 16'h0000, sck_out: 1'b1, sdo: 1'b1,
                   sdo_en: 1'b0, sck_en: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign link.sdo_o = r.sdo;
    assign link.sdo_oe = r.sdo_en;
    assign link.sck_dev_o = r.sck_out;
    assign link.sck_dev_oe = r.sck_en;
    assign link.sck_pullup = r.pull;
    assign busy = (r.st == ADCSR_CONVERT);
    assign int_mode = r.intm;
endmodule : adcsr_device

//--- design/adcsr_host.sv
// Host end: external SCK readout of one 32-bit frame per request.
// Assumes sdo and sck arrive from pins, asynchronous to clk.
`timescale 1ns/100ps
module adcsr_host
    import adcsr_pkg::*;
#(
    parameter int HALF = HOST_HALF_CYCLES
)
(
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Request: read one frame; stop_after aborts after that many bits
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [5:0] stop_after,
    // Result out through a two-entry buffer
    output logic res_valid,
    input wire logic res_ready,
    output logic [31:0] res_data,
    // Link
    adcsr_if.host link
);
    typedef enum logic [1:0]
    {
        HST_IDLE = 2'b00,
        HST_WAIT = 2'b01,
        HST_SHIFT = 2'b10,
        HST_DONE = 2'b11
    } adcsr_hst_t;

    typedef struct packed
    {
        logic [1:0] sdo_s;
        adcsr_hst_t st;
        logic cs_n;
        logic sck;
        logic [5:0] bits;
        logic [5:0] stop;
        logic [15:0] cnt;
        logic [32:0] sh;
        logic [1:0][31:0] buf_d;
        logic [1:0] cnt_b;
    } adcsr_host_t;

    adcsr_host_t r;
    adcsr_host_t next_r;
    logic push;
    logic pop;

    always_comb
    begin
        next_r = r;
        next_r.sdo_s = {r.sdo_s[0], link.sdo};
        push = 1'b0;
        pop = res_valid & res_ready;
        case (r.st)
            HST_IDLE:
            begin
                if (req_valid && r.cnt_b != 2'd2)
                begin
                    next_r.st = HST_WAIT;
                    next_r.cs_n = 1'b0;
                    next_r.stop = stop_after;
                    next_r.cnt = 16'h0000;
                end
            end
            HST_WAIT:
            begin
                next_r.cnt = r.cnt + 16'h0001;
                if (r.cnt > 16'h0004 && !r.sdo_s[1])
                begin
                    next_r.st = HST_SHIFT;
                    next_r.bits = 6'h00;
                    next_r.cnt = 16'h0000;
                end
            end
            HST_SHIFT:
            begin
                next_r.cnt = r.cnt + 16'h0001;
                if (r.cnt >= 16'(HALF - 1))
                begin
                    next_r.cnt = 16'h0000;
                    next_r.sck = ~r.sck;
                    if (!r.sck)
                    begin
                        next_r.sh = {r.sh[31:0], r.sdo_s[1]};
                        next_r.bits = r.bits + 6'h01;
                    end
                    else if (r.bits == 6'(FRAME_BITS))
                    begin
                        next_r.st = HST_DONE;
                    end
                    else if (r.stop != 6'h00 && r.bits >= r.stop)
                    begin
                        next_r.cs_n = 1'b1;
                        next_r.st = HST_DONE;
                    end
                end
            end
            default:
            begin
                // Select stays low past the 32nd fall so that fall counts
                next_r.cnt = r.cnt + 16'h0001;
                if (r.cnt >= 16'(HALF - 1))
                begin
                    next_r.cnt = 16'h0000;
                    next_r.cs_n = 1'b1;
                    next_r.st = HST_IDLE;
                    push = (r.bits == 6'(FRAME_BITS));
                end
            end
        endcase
        if (push && !pop)
        begin
            next_r.buf_d[r.cnt_b[0]] = r.sh[31:0];
            next_r.cnt_b = r.cnt_b + 2'd1;
        end
        else if (pop && !push)
        begin
            next_r.buf_d[0] = r.buf_d[1];
            next_r.cnt_b = r.cnt_b - 2'd1;
        end
        else if (pop && push)
        begin
            next_r.buf_d[0] = (r.cnt_b == 2'd1) ? r.sh[31:0] : r.buf_d[1];
            next_r.buf_d[1] = r.sh[31:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r <= '{sdo_s: 2'b11, st: HST_IDLE, cs_n: 1'b1, sck: 1'b0,
                   bits: 6'h00, stop: 6'h00, cnt: 16'h0000,
                   sh: 33'h0_0000_0000, buf_d: 64'h0, cnt_b: 2'd0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign req_ready = (r.st == HST_IDLE) && (r.cnt_b != 2'd2);
    assign res_valid = (r.cnt_b != 2'd0);
    assign res_data = r.buf_d[0];
    assign link.cs_n = r.cs_n;
    assign link.sck_host_o = r.sck;
    assign link.sck_host_oe = 1'b1;
endmodule : adcsr_host

//--- tb/adcsr_properties.sv
// Checker: timing relations on the link between the two ends.
// Assumes the bench feeds it the resolved link wires and the clock.
`timescale 1ns/100ps
module adcsr_properties
(
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sck_dev_oe,
    input wire logic sck_pullup,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Falling SCK edges seen in the current frame
    logic sck_q;
    logic [5:0] fall_cnt;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sck_q <= 1'b0;
            fall_cnt <= 6'h00;
        end
        else
        begin
            sck_q <= sck;
            if (cs_n)
                fall_cnt <= 6'h00;
            else if (sck_q && !sck)
                fall_cnt <= fall_cnt + 6'h01;
        end
    end

    // ==========================================================
    // Properties
    sequence last_fall;
        $fell(sck) && !cs_n && fall_cnt == 6'h1F;
    endsequence

    sdo_off_a: assert property (cs_n [*4] |-> !sdo_oe)
        else $error("sdo driven while deselected");
    sdo_on_a: assert property ($fell(cs_n) |-> ##[1:4] sdo_oe)
        else $error("flag not driven after select");
    ext_mode_a: assert property ($fell(cs_n) && !sck |-> !sck_dev_oe [*8])
        else $error("device drove sck in external mode");
    pullup_off_a: assert property ((!sck && !cs_n) [*4] |-> !sck_pullup)
        else $error("pull-up on while sck low");
    pullup_on_a: assert property ($rose(cs_n) |-> ##[1:4] sck_pullup)
        else $error("pull-up not restored on deselect");
    shift_edge_a: assert property
        (sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> !sck)
        else $error("sdo changed while sck high");
    new_conv_a: assert property
        (last_fall |-> ##[1:6] (cs_n || (sdo_oe && sdo_o)))
        else $error("no busy flag after last fall");
    busy_hold_a: assert property (last_fall ##6 !cs_n |-> sdo_o)
        else $error("busy flag dropped during conversion");
    pulse_count_a: assert property
        ($fell(sck) && !cs_n |-> fall_cnt < 6'h20)
        else $error("more than 32 sck pulses in frame");
endmodule : adcsr_properties

//--- tb/adc_serial_readout_modes_bench.sv
// Bench: host end reads the converter end over the shared link.
// Assumes both ends share clk; the bench resolves sck and sdo.
`timescale 1ns/100ps
module adc_serial_readout_modes_bench;
    import adcsr_pkg::*;
    localparam int CONV = 200;
    typedef struct packed {logic [31:0] r; logic [31:0] e;} adcsr_row_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rate_select_pin = 1'b0;
    logic [31:0] result_in = 32'h0;
    logic busy, int_mode, req_ready, res_valid;
    logic req_valid = 1'b0;
    logic res_ready = 1'b0;
    logic [5:0] stop_after = 6'h00;
    logic [31:0] res_data;
    int errors = 0;
    int check_count = 0;
    adcsr_row_t rows [4];
    adcsr_if link();

`define CHECK(got, exp, msg) begin check_count++; if ((got) !== (exp)) \
    begin errors++; $display("CHECK FAILED %0t %s", $time, msg); end end

    always #12.5 clk = ~clk;

    // ==========================================================
    // Wire resolution: sck pulled up, sdo idles high
    assign link.sck = link.sck_dev_oe ? link.sck_dev_o :
        link.sck_host_oe ? link.sck_host_o : link.sck_pullup;
    assign link.sdo = link.sdo_oe ? link.sdo_o : 1'b1;

    adcsr_device #(.CONV_LEN(CONV), .TEST_LEN(20),
        .CONV_DIV(CONV_CLK_CYCLES)) u_adcsr_device (.clk(clk),
        .sys_rst(sys_rst), .rate_select_pin(rate_select_pin),
        .result_in(result_in), .busy(busy), .int_mode(int_mode),
        .link(link));
    adcsr_host #(.HALF(HOST_HALF_CYCLES)) u_adcsr_host (.clk(clk),
        .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
        .stop_after(stop_after), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data), .link(link));
    adcsr_properties u_adcsr_properties (.clk(clk), .sys_rst(sys_rst),
        .cs_n(link.cs_n), .sck(link.sck), .sck_dev_oe(link.sck_dev_oe),
        .sck_pullup(link.sck_pullup), .sdo_o(link.sdo_o),
        .sdo_oe(link.sdo_oe));

    // ==========================================================
    // Tasks
    task automatic end_of_test;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic wait_cs(input logic v);
        int n;
        n = 0;
        while (link.cs_n !== v && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000)
            errors++;
    endtask : wait_cs

    // Request one frame; returns four cycles after cs_n is back high
    task automatic frame(input logic [31:0] r, input logic [5:0] stop);
        int n;
        n = 0;
        result_in = r;
        stop_after = stop;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000)
            errors++;
        @(negedge clk);
        req_valid = 1'b0;
        wait_cs(1'b0);
        wait_cs(1'b1);
        repeat (4) @(negedge clk);
    endtask : frame

    task automatic take(input logic [31:0] e);
        int n;
        n = 0;
        while (res_valid !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000)
            errors++;
        `CHECK(res_data, e, "result word")
        res_ready = 1'b1;
        @(negedge clk);
        res_ready = 1'b0;
    endtask : take

    // ==========================================================
    // Main sequence
    initial
    begin
        rows[0] = '{32'hA5A5_5A5A, 32'h52D2_AD2D};
        rows[1] = '{32'hFFFF_FFFF, 32'h7FFF_FFFF};
        rows[2] = '{32'h0000_0001, 32'h0000_0000};
        rows[3] = '{32'h8000_0001, 32'h4000_0000};
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        foreach (rows[i])
        begin
            frame(rows[i].r, 6'h00);
            take(rows[i].e);
        end
        // Abort after five bits: no word, conversion restarts at once
        frame(32'h1234_5678, 6'h05);
        `CHECK(busy, 1'b1, "no restart on abort")
        `CHECK(res_valid, 1'b0, "aborted frame pushed")
        frame(32'hC3C3_3C3C, 6'h00);
        take(32'h61E1_9E1E);
        // Receiver stalls across two frames, then drains
        frame(32'h0F0F_F0F0, 6'h00);
        frame(32'hF0F0_0F0F, 6'h00);
        `CHECK(req_ready, 1'b0, "request taken with buffer full")
        take(32'h0787_F878);
        take(32'h7878_0787);
        `CHECK(res_valid, 1'b0, "buffer not empty")
        // Reset in mid-frame
        result_in = 32'h0000_0000;
        req_valid = 1'b1;
        wait_cs(1'b0);
        req_valid = 1'b0;
        repeat (40) @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        `CHECK(link.cs_n, 1'b1, "cs_n after reset")
        `CHECK(link.sdo_oe, 1'b0, "sdo after reset")
        `CHECK(link.sck_pullup, 1'b1, "pull-up after reset")
        `CHECK(int_mode, 1'b1, "mode after reset")
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        `CHECK(int_mode, 1'b0, "low SCK at reset end")
        `CHECK(res_valid, 1'b0, "word left after reset")
        frame(32'h8765_4321, 6'h00);
        take(32'h43B2_A190);
        end_of_test();
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        errors++;
        end_of_test();
    end
endmodule : adc_serial_readout_modes_bench
